// *** design/weigh_pkg.sv ***
// Shared constants and carrier types for the weighing channel block.
// Assumes a single 125 MHz core clock and host bits on that same clock.
package weigh_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int STAB_UNIT_NS = 100_000_000;
    localparam int STAB_UNIT_CYCLES = STAB_UNIT_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Ranges, sizes and codes
    // ------------------------------------------------------------------
    localparam int RAW_FULL_SCALE = 10000;
    localparam int BUF_DEPTH = 600;
    localparam int BUF_PRE_DEFAULT = 200;
    localparam int BUF_LEN_DEFAULT = 600;
    localparam int IDX_W = 10;
    localparam int SETTING_MAX = 100;
    localparam int OVERWEIGHT_DIVS = 9;
    localparam int PERCENT_SCALE = 100;
    localparam int FIFO_DEPTH = 16;
    localparam int WEIGHT_W = 24;
    localparam int RAW_W = 16;
    localparam logic [7:0] READOUT_CMD = 8'h73;

    // One conversion result from the analogue front end.
    typedef struct packed {
        logic [RAW_W-1:0] raw;
        logic signed [WEIGHT_W-1:0] weight;
        logic overRange;
    } sample_type;

    // Channel settings held by the host.
    typedef struct packed {
        logic signed [WEIGHT_W-1:0] capacity;
        logic signed [WEIGHT_W-1:0] division;
        logic signed [WEIGHT_W-1:0] highLimit;
        logic signed [WEIGHT_W-1:0] lowLimit;
        logic signed [WEIGHT_W-1:0] zeroRangeLimit;
        logic signed [WEIGHT_W-1:0] calZero;
        logic [7:0] errPercent;
        logic [7:0] stabRange;
        logic [7:0] stabTime;
        logic detectEn;
    } config_type;

    // Sticky alarm and error indications.
    typedef struct packed {
        logic inputSignal;
        logic overweight;
        logic zeroRange;
        logic overRange;
        logic grossHigh;
        logic grossLow;
    } alarm_type;

endpackage

// *** design/sample_fifo.sv ***
// Sample FIFO between the front end and the channel logic.
// Assumes writer and reader on the same clock; synchronous reset.
module sample_fifo #(
    parameter int WIDTH = 41,
    parameter int DEPTH = weigh_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;

    // ------------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------------
    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    wire [AW-1:0] wrNext = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    wire [AW-1:0] rdNext = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;

    // Full and empty follow the occupancy count.
    assign inReady = (count_q != (AW + 1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];

    // Storage write.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wrPtr_q <= wrNext;
            if (pop) rdPtr_q <= rdNext;
            count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule // sample_fifo

// *** design/weigh_channel_status_logic.sv ***
// Status and control logic of one weighing channel.
// Assumes host request bits and samples arrive on core_clk.
// What this block does
// R1 - Request rising starts buffer filling; request falling stops capture.
// R2 - Trigger rising marks instant; configured samples recorded around it.
// R3 - Capture-complete sets after all samples; buffer readable via code 115.
// R4 - Capture-complete clears when the request bit drops.
// R5 - Retrigger clears capture-complete until the new capture finishes.
// R6 - Raw conversion value reported in 0 to 10000.
// R7 - Largest and smallest gross weight tracked from reset onward.
// R8 - Alarm-clear request clears pending alarm indications.
// R9 - Error-clear request clears pending error indications.
// R10 - Zero-set makes the present reading the new zero reference.
// R11 - Zero-return drops user zero shift, restoring calibrated zero.
// R12 - Stable output high while reading judged stable, else low.
// R13 - Centre-point output follows the centre-point state.
// R14 - Zero-detected output follows the zero state.
// R15 - Zero-set and zero-return completion bits high one scan period.
// R16 - Input-signal error when weight exceeds capacity plus percentage.
// R17 - Overweight when weight exceeds capacity plus nine divisions.
// R18 - Zero-set outside permitted range raises zero-out-of-range warning.
// R19 - Converter overrange warning when detection is enabled.
// R20 - Gross high alarm while gross above upper limit.
// R21 - Gross low alarm while gross below lower limit.
// R22 - Summary error flag on overrange or overweight.
// R23 - Buffer holds at most 600 samples; length 1 to 600.
// R24 - Pre-trigger sample count 0 to 599, default 200.
// R25 - Stable when variation under range for stability time; zero disables.
// R26 - Alarm and error indications stay until the matching clear.
module weigh_channel_status_logic #(
    parameter int TICK_CYCLES = weigh_pkg::STAB_UNIT_CYCLES,
    parameter int DEPTH = weigh_pkg::BUF_DEPTH,
    parameter int FIFO_DEPTH = weigh_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sampleValid,
    output logic sampleReady,
    input wire weigh_pkg::sample_type sampleIn,
    input wire weigh_pkg::config_type cfg,
    input wire logic [weigh_pkg::IDX_W-1:0] bufPre,
    input wire logic [weigh_pkg::IDX_W-1:0] bufLen,
    input wire logic scanTick,
    input wire logic bufferRequest,
    input wire logic captureTrig,
    input wire logic alarmClearReq,
    input wire logic errorClearReq,
    input wire logic zeroSetReq,
    input wire logic zeroReturnReq,
    input wire logic readValid,
    input wire logic [7:0] readCmd,
    input wire logic [weigh_pkg::IDX_W-1:0] readIndex,
    output logic readAck,
    output logic readOk,
    output logic signed [weigh_pkg::WEIGHT_W-1:0] readData,
    output logic captureDone,
    output logic [weigh_pkg::RAW_W-1:0] rawValue,
    output logic signed [weigh_pkg::WEIGHT_W-1:0] weightValue,
    output logic signed [weigh_pkg::WEIGHT_W-1:0] maxGross,
    output logic signed [weigh_pkg::WEIGHT_W-1:0] minGross,
    output logic stable,
    output logic centrePoint,
    output logic zeroDetected,
    output logic zeroSetDone,
    output logic zeroReturnDone,
    output weigh_pkg::alarm_type alarms,
    output logic errorFlag
);
    localparam int AW = weigh_pkg::IDX_W;
    localparam int WW = weigh_pkg::WEIGHT_W;
    typedef enum logic [1:0] {BUF_OFF, BUF_ARMED, BUF_POST, BUF_DONE}
        buf_state_type;

    // ------------------------------------------------------------------
    // Sample FIFO; the drain stalls while a buffer readout is served.
    // ------------------------------------------------------------------
    weigh_pkg::sample_type popData;
    logic popValid;
    wire popReady = ~readValid;
    wire take = popValid & popReady;

    sample_fifo #(
        .WIDTH($bits(weigh_pkg::sample_type)),
        .DEPTH(FIFO_DEPTH)
    ) i_sample_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(sampleIn),
        .outValid(popValid),
        .outReady(popReady),
        .outData(popData)
    );

    // ------------------------------------------------------------------
    // Edge detection of host bits
    // ------------------------------------------------------------------
    logic reqPrev_q, trigPrev_q, zsPrev_q, zrPrev_q;
    wire reqRise = bufferRequest & ~reqPrev_q;
    wire trigRise = captureTrig & ~trigPrev_q;
    wire zsRise = zeroSetReq & ~zsPrev_q;
    wire zrRise = zeroReturnReq & ~zrPrev_q;

    // Previous values of the host request bits.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reqPrev_q <= 1'b0;
            trigPrev_q <= 1'b0;
            zsPrev_q <= 1'b0;
            zrPrev_q <= 1'b0;
        end else begin
            reqPrev_q <= bufferRequest;
            trigPrev_q <= captureTrig;
            zsPrev_q <= zeroSetReq;
            zrPrev_q <= zeroReturnReq;
        end
    end

    // ------------------------------------------------------------------
    // Capture buffer
    // ------------------------------------------------------------------
    buf_state_type st_q, st_d;
    logic [AW-1:0] wrPtr_q, wrPtr_d, fill_q, fill_d;
    logic [AW-1:0] cnt_q, cnt_d, start_q, start_d;
    logic signed [WW-1:0] bufMem [DEPTH];

    // Length is clamped to 1..DEPTH, pre-trigger count below length.
    wire [AW-1:0] lenMax = AW'(DEPTH);
    wire [AW-1:0] effLen = (bufLen == '0) ? AW'(1) :
                           (bufLen > lenMax) ? lenMax : bufLen; // R23
    wire [AW-1:0] effPre = (bufPre >= effLen) ? effLen - 1'b1 :
                           bufPre; // R24
    wire [AW-1:0] wrInc = (wrPtr_q == lenMax - 1'b1) ? '0 :
                          wrPtr_q + 1'b1;
    wire armStore = take & (st_q == BUF_ARMED) & (effPre != '0);
    wire storeEn = armStore | (take & (st_q == BUF_POST)); // R1
    wire [AW:0] backSub = {1'b0, wrPtr_d} - {1'b0, fill_d};
    wire [AW-1:0] backPtr = backSub[AW] ?
                            backSub[AW-1:0] + lenMax : backSub[AW-1:0];
    wire [AW-1:0] postCnt = cnt_q + AW'(storeEn);

    // Capture sequencing; a falling request always switches off.
    always_comb begin
        st_d = st_q;
        wrPtr_d = storeEn ? wrInc : wrPtr_q;
        fill_d = fill_q;
        cnt_d = cnt_q;
        start_d = start_q;
        if (armStore && fill_q < effPre) begin
            fill_d = fill_q + 1'b1;
        end
        if (!bufferRequest) begin
            st_d = BUF_OFF; // R4
        end else begin
            unique case (st_q)
                BUF_OFF: begin
                    if (reqRise) begin
                        st_d = BUF_ARMED; // R1
                        wrPtr_d = '0;
                        fill_d = '0;
                    end
                end
                BUF_ARMED: begin
                    if (trigRise) begin
                        st_d = BUF_POST; // R2
                        start_d = backPtr;
                        cnt_d = fill_d;
                    end
                end
                BUF_POST: begin
                    cnt_d = postCnt;
                    if (trigRise) begin
                        start_d = wrPtr_d; // R5
                        cnt_d = '0;
                    end else if (postCnt >= effLen) begin
                        st_d = BUF_DONE; // R3
                    end
                end
                BUF_DONE: begin
                    if (trigRise) begin
                        st_d = BUF_POST; // R5
                        start_d = wrPtr_q;
                        cnt_d = '0;
                    end
                end
            endcase
        end
    end

    // Capture state registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= BUF_OFF;
            wrPtr_q <= '0;
            fill_q <= '0;
            cnt_q <= '0;
            start_q <= '0;
        end else begin
            st_q <= st_d;
            wrPtr_q <= wrPtr_d;
            fill_q <= fill_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
        end
    end

    assign captureDone = (st_q == BUF_DONE); // R3

    // ------------------------------------------------------------------
    // Buffer readout by command code
    // ------------------------------------------------------------------
    wire [AW:0] rdSum = {1'b0, start_q} + {1'b0, readIndex};
    wire [AW:0] rdWrap = rdSum - {1'b0, lenMax};
    wire [AW-1:0] rdAddr = (rdSum >= {1'b0, lenMax}) ?
                           rdWrap[AW-1:0] : rdSum[AW-1:0];
    wire rdGood = (readCmd == weigh_pkg::READOUT_CMD) & captureDone &
                  (readIndex < effLen);
    logic readAck_q, readOk_q;
    logic signed [WW-1:0] readData_q;

    // Readout answers one cycle after each request.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            readAck_q <= 1'b0;
            readOk_q <= 1'b0;
            readData_q <= '0;
        end else begin
            readAck_q <= readValid;
            readOk_q <= readValid & rdGood;
            if (readValid && rdGood) readData_q <= bufMem[rdAddr]; // R3
        end
    end
    assign readAck = readAck_q;
    assign readOk = readOk_q;
    assign readData = readData_q;

    // ------------------------------------------------------------------
    // Readings, zero handling and extremes
    // ------------------------------------------------------------------
    logic signed [WW-1:0] shift_q, gross_q, lastW_q, max_q, min_q;
    logic [weigh_pkg::RAW_W-1:0] raw_q;
    logic seen_q, zsPend_q, zrPend_q, zsOut_q, zrOut_q;
    wire signed [WW-1:0] grossIn = popData.weight - cfg.calZero - shift_q;
    wire signed [WW-1:0] shiftNew = lastW_q - cfg.calZero;
    wire signed [WW-1:0] shiftAbs = shiftNew[WW-1] ? -shiftNew : shiftNew;
    wire zeroBad = cfg.detectEn & (shiftAbs > cfg.zeroRangeLimit); // R18
    wire [weigh_pkg::RAW_W-1:0] rawTop =
        weigh_pkg::RAW_W'(weigh_pkg::RAW_FULL_SCALE);

    // Sample storage; gross weight of each sample taken while storeEn is high.
    always_ff @(posedge core_clk) begin
        if (storeEn) begin
            bufMem[wrPtr_q] <= grossIn;
        end
    end

    // Gross, raw value and zero shift.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_q <= '0;
            gross_q <= '0;
            lastW_q <= '0;
            raw_q <= '0;
        end else begin
            if (take) begin
                gross_q <= grossIn;
                lastW_q <= popData.weight;
                raw_q <= (popData.raw > rawTop) ? rawTop : popData.raw; // R6
            end
            if (zrRise) shift_q <= '0; // R11
            else if (zsRise && !zeroBad) shift_q <= shiftNew; // R10
        end
    end

    // Running maximum and minimum gross weight.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seen_q <= 1'b0;
            max_q <= '0;
            min_q <= '0;
        end else if (take) begin
            seen_q <= 1'b1;
            if (!seen_q || grossIn > max_q) max_q <= grossIn; // R7
            if (!seen_q || grossIn < min_q) min_q <= grossIn; // R7
        end
    end

    // Completion pulses are aligned to host scan boundaries.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            zsPend_q <= 1'b0;
            zrPend_q <= 1'b0;
            zsOut_q <= 1'b0;
            zrOut_q <= 1'b0;
        end else begin
            zsPend_q <= (zsRise & ~zeroBad & ~zrRise) |
                        (zsPend_q & ~scanTick);
            zrPend_q <= zrRise | (zrPend_q & ~scanTick);
            if (scanTick) begin
                zsOut_q <= zsPend_q; // R15
                zrOut_q <= zrPend_q; // R15
            end
        end
    end

    assign rawValue = raw_q;
    assign weightValue = gross_q;
    assign maxGross = max_q;
    assign minGross = min_q;
    assign zeroSetDone = zsOut_q;
    assign zeroReturnDone = zrOut_q;

    // ------------------------------------------------------------------
    // Stability, centre point and zero state
    // ------------------------------------------------------------------
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_q;
    logic [7:0] stabCnt_q;
    logic signed [WW-1:0] stabRef_q;
    wire unitTick = (tick_q == '0);
    wire signed [WW-1:0] drift = grossIn - stabRef_q;
    wire signed [WW-1:0] driftAbs = drift[WW-1] ? -drift : drift;
    wire signed [31:0] stabBand = 32'(cfg.division) *
                                  32'($signed({1'b0, cfg.stabRange}));
    wire moved = take & (32'(driftAbs) >= stabBand);

    // Stability timer in units of the stability tick.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_q <= '0;
            stabCnt_q <= '0;
            stabRef_q <= '0;
        end else begin
            tick_q <= unitTick ? $bits(tick_q)'(TICK_CYCLES - 1) :
                      tick_q - 1'b1;
            if (moved) begin
                stabRef_q <= grossIn; // R25
                stabCnt_q <= '0;
            end else if (unitTick && stabCnt_q < cfg.stabTime) begin
                stabCnt_q <= stabCnt_q + 1'b1;
            end
        end
    end

    wire signed [WW-1:0] grossAbs = gross_q[WW-1] ? -gross_q : gross_q;
    assign stable = (cfg.stabTime != '0) &
                    (stabCnt_q >= cfg.stabTime); // R12
    assign centrePoint = ({grossAbs, 2'b00} <
                          (WW + 2)'(cfg.division)); // R13
    assign zeroDetected = stable & (grossAbs <= cfg.division); // R14

    // ------------------------------------------------------------------
    // Alarm and error conditions
    // ------------------------------------------------------------------
    wire signed [39:0] grossPct = 40'(gross_q) *
                                  40'(weigh_pkg::PERCENT_SCALE);
    wire signed [39:0] capPct = 40'(cfg.capacity) *
        (40'(weigh_pkg::PERCENT_SCALE) +
         40'($signed({1'b0, cfg.errPercent})));
    wire signed [31:0] owLim = 32'(cfg.capacity) +
        32'(cfg.division) * 32'(weigh_pkg::OVERWEIGHT_DIVS);
    weigh_pkg::alarm_type cond, alarm_q, clearMask;

    assign cond.inputSignal = cfg.detectEn & (grossPct > capPct); // R16
    assign cond.overweight = cfg.detectEn & (32'(gross_q) > owLim); // R17
    assign cond.zeroRange = zsRise & zeroBad; // R18
    assign cond.overRange = cfg.detectEn & take & popData.overRange; // R19
    assign cond.grossHigh = gross_q > cfg.highLimit; // R20
    assign cond.grossLow = gross_q < cfg.lowLimit; // R21

    // Alarms clear with the alarm request, errors with the error request.
    assign clearMask.inputSignal = errorClearReq; // R9
    assign clearMask.overweight = alarmClearReq; // R8
    assign clearMask.zeroRange = errorClearReq;
    assign clearMask.overRange = errorClearReq;
    assign clearMask.grossHigh = alarmClearReq;
    assign clearMask.grossLow = alarmClearReq;

    // Sticky indications; a new event wins over a clear.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarm_q <= '0;
        end else begin
            alarm_q <= (alarm_q & ~clearMask) | cond; // R26
        end
    end

    assign alarms = alarm_q;
    assign errorFlag = alarm_q.overRange | alarm_q.overweight; // R22

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_retrig;
        bufferRequest && captureTrig && !trigPrev_q && st_q != BUF_OFF;
    endsequence
    property p_req_drop;
        !bufferRequest |=> !captureDone;
    endproperty
    a_req_drop: assert property (p_req_drop) // R4
        else $error("capture done stayed after request drop");
    property p_done_count;
        $rose(captureDone) |-> cnt_q >= effLen;
    endproperty
    a_done_count: assert property (p_done_count) // R3
        else $error("capture done before all samples");
    property p_retrig;
        s_retrig ##1 bufferRequest |-> !captureDone;
    endproperty
    a_retrig: assert property (p_retrig) // R5
        else $error("capture done not cleared by retrigger");
    property p_zs_scan;
        $rose(zeroSetDone) |-> $past(scanTick) ##1 zeroSetDone;
    endproperty
    a_zs_scan: assert property (p_zs_scan) // R15
        else $error("zero set done not scan aligned");
    property p_sticky;
        alarms.grossHigh && !alarmClearReq |=> alarms.grossHigh;
    endproperty
    a_sticky: assert property (p_sticky) // R26
        else $error("gross high alarm lost without clear");
    property p_high;
        gross_q > cfg.highLimit |=> alarms.grossHigh;
    endproperty
    a_high: assert property (p_high) // R20
        else $error("gross high alarm missing");
    property p_errflag;
        alarms.overweight |-> errorFlag;
    endproperty
    a_errflag: assert property (p_errflag) // R22
        else $error("error flag missing on overweight");
    property p_extremes;
        seen_q |-> maxGross >= minGross;
    endproperty
    a_extremes: assert property (p_extremes) // R7
        else $error("maximum below minimum");
    property p_stab_off;
        cfg.stabTime == '0 |-> !stable && !zeroDetected;
    endproperty
    a_stab_off: assert property (p_stab_off) // R25
        else $error("stable with stability time zero");
    property p_zret;
        zrRise |=> shift_q == '0 && zrPend_q;
    endproperty
    a_zret: assert property (p_zret) // R11
        else $error("zero return did not clear shift");
endmodule // weigh_channel_status_logic

// *** testbench/host_scan_model.sv ***
// Host scan model: one scan-boundary tick per host scan period.
// Assumes the channel's core clock and synchronous reset.
module host_scan_model #(parameter int SCAN = 6) (
    input wire logic core_clk,
    input wire logic rst,
    output logic scanTick
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Counts cycles and ends each scan with a one-cycle tick.
    always @(posedge core_clk) begin
        cnt <= (rst || cnt == SCAN - 1) ? 0 : cnt + 1;
        scanTick <= !rst && cnt == SCAN - 1;
    end
endmodule // host_scan_model

// *** testbench/weigh_channel_status_logic_bench.sv ***
// Self-checking bench for the weighing channel status logic.
// Assumes the host scan model; the bench drives samples and requests.
module weigh_channel_status_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SCAN = 6;
    logic core_clk = 0, rst = 1, sampleValid = 0, bufferRequest = 0;
    logic captureTrig = 0, alarmClearReq = 0, errorClearReq = 0;
    logic zeroSetReq = 0, zeroReturnReq = 0, readValid = 0, scanTick;
    logic sampleReady, readAck, readOk, captureDone, stable, centrePoint;
    logic zeroDetected, zeroSetDone, zeroReturnDone, errorFlag;
    logic [7:0] readCmd = 8'h73;
    logic [9:0] readIndex = 10'h000, bufPre = 10'h001, bufLen = 10'h003;
    logic signed [23:0] readData, weightValue, maxGross, minGross;
    logic [15:0] rawValue;
    weigh_pkg::sample_type sampleIn = '0;
    weigh_pkg::config_type cfg = '{24'h3E8, 24'hA, 24'h1F4, 24'hFFFE0C,
        24'h64, 24'h0, 8'hA, 8'h1, 8'h0, 1'b1};
    weigh_pkg::alarm_type alarms;
    int badCount = 0, nCompared = 0, k;
    // Rows: raw input, weight input, expected raw output.
    logic [23:0] rows [3][3] = '{'{24'h1388, 24'h64, 24'h1388},
        '{24'h2EE0, 24'hFFFDA8, 24'h2710}, '{24'h2710, 24'h12C, 24'h2710}};
    // Core clock at 125 MHz.
    always #4 core_clk = ~core_clk;
    host_scan_model #(.SCAN(SCAN)) i_host_scan_model (.core_clk, .rst,
        .scanTick);
    weigh_channel_status_logic #(.TICK_CYCLES(8))
        i_weigh_channel_status_logic (.core_clk, .rst, .sampleValid,
        .sampleReady, .sampleIn, .cfg, .bufPre, .bufLen, .scanTick,
        .bufferRequest, .captureTrig, .alarmClearReq, .errorClearReq,
        .zeroSetReq, .zeroReturnReq, .readValid, .readCmd, .readIndex,
        .readAck, .readOk, .readData, .captureDone, .rawValue, .weightValue,
        .maxGross, .minGross, .stable, .centrePoint, .zeroDetected,
        .zeroSetDone, .zeroReturnDone, .alarms, .errorFlag);
    task giveVerdict;
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One sample through the FIFO and into the output registers.
    task push(input logic [15:0] r, input logic [23:0] w);
        @(posedge core_clk);
        sampleIn <= '{r, w, 1'b0};
        sampleValid <= 1'b1;
        @(posedge core_clk);
        sampleValid <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task rd(input logic [7:0] c);
        @(posedge core_clk);
        readValid <= 1'b1;
        readCmd <= c;
        @(posedge core_clk);
        readValid <= 1'b0;
        #1;
    endtask
    // One-cycle request: 0 alarm, 1 zero set, 2 zero return, 3 error clear.
    task req(input int n);
        @(posedge core_clk);
        {errorClearReq, zeroReturnReq, zeroSetReq, alarmClearReq} <= 4'(1<<n);
        @(posedge core_clk);
        {errorClearReq, zeroReturnReq, zeroSetReq, alarmClearReq} <= '0;
        @(posedge core_clk);
        #1;
    endtask
    // Measures how many cycles a completion bit stays high.
    task doneWidth(input bit ret);
        k = 0;
        while ((ret ? zeroReturnDone : zeroSetDone) !== 1'b1) begin
            @(posedge core_clk);
            #1;
            k++;
            if (k > 60) begin
                badCount++;
                giveVerdict();
            end
        end
        k = 0;
        while ((ret ? zeroReturnDone : zeroSetDone) === 1'b1 && k < 60) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk(24'(k), 24'(SCAN));
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(maxGross, 24'h0);
        chk(24'({centrePoint, stable, alarms}), 24'h80);
        for (int i = 0; i < 3; i++) begin
            push(rows[i][0][15:0], rows[i][1]);
            chk(24'(rawValue), rows[i][2]);
            chk(weightValue, rows[i][1]);
        end
        chk(maxGross, 24'h12C);
        chk(minGross, 24'hFFFDA8);
        $display("test readings done");
        push(16'h0, 24'h258);
        chk(24'(alarms), 24'h3);
        push(16'h0, 24'h44D);
        chk(24'({alarms.overweight, alarms.inputSignal}), 24'h3);
        chk(24'(errorFlag), 24'h1);
        push(16'h0, 24'h64);
        chk(24'(alarms.grossHigh), 24'h1);
        req(0);
        chk(24'(alarms), 24'h20);
        req(3);
        chk(24'(alarms), 24'h0);
        $display("test alarms done");
        @(posedge core_clk);
        bufferRequest <= 1'b1;
        push(16'h0, 24'h11);
        @(posedge core_clk);
        captureTrig <= 1'b1;
        push(16'h0, 24'h22);
        chk(24'(captureDone), 24'h0);
        push(16'h0, 24'h33);
        chk(24'(captureDone), 24'h1);
        rd(8'h73);
        chk(24'({readAck, readOk}), 24'h3);
        chk(readData, 24'h11);
        rd(8'h72);
        chk(24'({readAck, readOk}), 24'h2);
        @(posedge core_clk);
        captureTrig <= 1'b0;
        @(posedge core_clk);
        captureTrig <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk(24'(captureDone), 24'h0);
        for (int i = 0; i < 3; i++) push(16'h0, 24'h44);
        chk(24'(captureDone), 24'h1);
        @(posedge core_clk);
        bufferRequest <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(24'(captureDone), 24'h0);
        $display("test capture done");
        push(16'h0, 24'h28);
        req(1);
        doneWidth(1'b0);
        push(16'h0, 24'h46);
        chk(weightValue, 24'h1E);
        req(2);
        doneWidth(1'b1);
        push(16'h0, 24'h46);
        chk(weightValue, 24'h46);
        $display("test zero done");
        @(posedge core_clk);
        {readValid, sampleValid} <= 2'h3;
        repeat (20) @(posedge core_clk);
        #1;
        chk(24'(sampleReady), 24'h0);
        @(posedge core_clk);
        {readValid, sampleValid} <= 2'h0;
        repeat (20) @(posedge core_clk);
        #1;
        chk(24'(sampleReady), 24'h1);
        $display("test fifo done");
        giveVerdict();
    end
endmodule // weigh_channel_status_logic_bench
